// >>> src/crg_cfg.svh
// timing, register and field constants for the cpu reset and init generator
`ifndef CRG_CFG_SVH
`define CRG_CFG_SVH
`define CRG_CLK_HZ          25000000
`define CRG_HOLD_US         1000
`define CRG_HOLD_CYC        ((`CRG_CLK_HZ / 1000000) * `CRG_HOLD_US)
`define CRG_CFG_EXTRA_CYC   2
`define CRG_INIT_CYC        4
`define CRG_CNT_W           16
`define CRG_INIT_W          3
`define CRG_REG_OFS         8'h93
`define CRG_REG_RST         8'h00
`define CRG_BIT_SOFT        1
`define CRG_BIT_GO          2
`define CRG_BIT_BIST        3
`define CRG_IOQ_NORMAL      1'b0
`endif

// >>> src/crg_pkg.sv
// types shared by the cpu reset and init generator
package crg_pkg;
  typedef struct packed {
    logic ecc_error_strap_pin;
    logic check_bit0_strap_pin;
    logic mem_cke_strap_pin;
  } crg_straps_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crg_cfg_wr_t;

  typedef enum logic [2:0] {
    CRG_ST_RESET = 3'b001,
    CRG_ST_HOLD  = 3'b010,
    CRG_ST_RUN   = 3'b100
  } crg_state_t;
endpackage : crg_pkg

// >>> src/crg_reset_gen.sv
// cpu reset, configuration reset, strap capture and processor init generator
//
// What this block does
// - while system reset input is low, assert processor and configuration reset outputs.
// - hold processor reset 1 ms after system reset input rises.
// - hold configuration reset 1 ms plus two host clocks after the rise.
// - processor reset assertion is synchronous to the host clock.
// - capture ecc error, check bit 0 and cke straps at reset release.
// - on shutdown cycle, complete with no-data response, then init for 4+ clocks.
// - register 93h bit3 clear, bit1 set, bit2 rising write pulses init 4+ clocks.
// - self test mode forces in-order queue depth of one.
// - host logic runs from the externally supplied host clock.
`timescale 1ns/1ps
`include "crg_cfg.svh"
module crg_reset_gen
  import crg_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_system_reset_in_n,
  input  wire crg_pkg::crg_straps_t i_straps,
  input  wire crg_pkg::crg_cfg_wr_t i_cfg_wr,
  input  wire logic                 i_shutdown_cycle,
  output logic                      o_processor_reset_out_n,
  output logic                      o_config_reset_out_n,
  output logic                      o_no_data_response,
  output logic                      o_init_n,
  output logic                      o_bist_req,
  output logic                      o_in_order_queue_depth_one,
  output crg_pkg::crg_straps_t      o_straps,
  output logic [7:0]                o_cpu_reset_control
);
  import crg_pkg::*;

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  localparam logic [`CRG_CNT_W-1:0] HOLD_CNT = `CRG_CNT_W'(`CRG_HOLD_CYC);
  localparam logic [`CRG_CNT_W-1:0] CFG_CNT  = `CRG_CNT_W'(`CRG_HOLD_CYC + `CRG_CFG_EXTRA_CYC);

  crg_state_t            state;
  crg_state_t            next_state;
  logic [`CRG_CNT_W-1:0] cnt;
  logic [`CRG_CNT_W-1:0] next_cnt;
  logic                  cpu_rst_n;
  logic                  next_cpu_rst_n;
  logic                  cfg_rst_n;
  logic                  next_cfg_rst_n;
  crg_straps_t           straps;
  crg_straps_t           next_straps;
  logic                  sys_d;

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_cpu_rst_n = cpu_rst_n;
    next_cfg_rst_n = cfg_rst_n;
    next_straps    = straps;
    case (state)
      CRG_ST_RESET:
      begin
        next_cpu_rst_n = 1'b0;
        next_cfg_rst_n = 1'b0;
        next_cnt       = '0;
        if (i_system_reset_in_n && !sys_d)
        begin
          next_straps = i_straps;
          next_state  = CRG_ST_HOLD;
        end
      end
      CRG_ST_HOLD:
      begin
        next_cnt = cnt + `CRG_CNT_W'(1);
        if (next_cnt >= HOLD_CNT)
          next_cpu_rst_n = 1'b1;
        if (next_cnt >= CFG_CNT)
        begin
          next_cfg_rst_n = 1'b1;
          next_state     = CRG_ST_RUN;
        end
      end
      CRG_ST_RUN:
        next_state = CRG_ST_RUN;
      default:
        next_state = CRG_ST_RESET;
    endcase
    if (!i_system_reset_in_n)
    begin
      next_state     = CRG_ST_RESET;
      next_cpu_rst_n = 1'b0;
      next_cfg_rst_n = 1'b0;
      next_cnt       = '0;
    end
  end

  // registered on the host clock so assertion is clock synchronous
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state     <= CRG_ST_RESET;
      cnt       <= '0;
      cpu_rst_n <= 1'b0;
      cfg_rst_n <= 1'b0;
      straps    <= '0;
      sys_d     <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      cpu_rst_n <= next_cpu_rst_n;
      cfg_rst_n <= next_cfg_rst_n;
      straps    <= next_straps;
      sys_d     <= i_system_reset_in_n;
    end
  end

  // ----------------------------------------
  // reset control register and init pulse
  // ----------------------------------------
  logic [7:0]             ctl;
  logic [7:0]             next_ctl;
  logic [`CRG_INIT_W-1:0] icnt;
  logic [`CRG_INIT_W-1:0] next_icnt;
  logic                   nodata;
  logic                   next_nodata;
  logic                   sd_pend;
  logic                   next_sd_pend;
  logic                   wr_hit;

  assign wr_hit = i_cfg_wr.wr && (i_cfg_wr.addr == `CRG_REG_OFS);

  always_comb
  begin
    next_ctl     = ctl;
    next_icnt    = icnt;
    next_nodata  = 1'b0;
    next_sd_pend = sd_pend;
    if (icnt != '0)
      next_icnt = icnt - `CRG_INIT_W'(1);
    if (wr_hit)
    begin
      next_ctl = i_cfg_wr.wdata;
      if (!i_cfg_wr.wdata[`CRG_BIT_BIST] && i_cfg_wr.wdata[`CRG_BIT_SOFT]
          && i_cfg_wr.wdata[`CRG_BIT_GO] && !ctl[`CRG_BIT_GO])
        next_icnt = `CRG_INIT_W'(`CRG_INIT_CYC);
    end
    // the pending clear comes first so a back-to-back shutdown is not lost
    if (sd_pend)
    begin
      next_icnt    = `CRG_INIT_W'(`CRG_INIT_CYC);
      next_sd_pend = 1'b0;
    end
    if (i_shutdown_cycle)
    begin
      next_nodata  = 1'b1;
      next_sd_pend = 1'b1;
    end
    if (state != CRG_ST_RUN)
    begin
      next_ctl     = `CRG_REG_RST;
      next_icnt    = '0;
      next_sd_pend = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctl     <= `CRG_REG_RST;
      icnt    <= '0;
      nodata  <= 1'b0;
      sd_pend <= 1'b0;
    end
    else
    begin
      ctl     <= next_ctl;
      icnt    <= next_icnt;
      nodata  <= next_nodata;
      sd_pend <= next_sd_pend;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic init_n_q;
  logic bist_q;
  logic ioq_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      init_n_q <= 1'b1;
      bist_q   <= 1'b0;
      ioq_q    <= `CRG_IOQ_NORMAL;
    end
    else
    begin
      init_n_q <= (next_icnt == '0);
      bist_q   <= next_ctl[`CRG_BIT_BIST];
      ioq_q    <= next_ctl[`CRG_BIT_BIST];
    end
  end

  assign o_processor_reset_out_n    = cpu_rst_n;
  assign o_config_reset_out_n       = cfg_rst_n;
  assign o_no_data_response         = nodata;
  assign o_init_n                   = init_n_q;
  assign o_bist_req                 = bist_q;
  assign o_in_order_queue_depth_one = ioq_q;
  assign o_straps                   = straps;
  assign o_cpu_reset_control        = ctl;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_init_start;
    $fell(o_init_n);
  endsequence
  sequence s_init_hold;
    !o_init_n [*4];
  endsequence

  rst_low_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_system_reset_in_n |=> !o_processor_reset_out_n && !o_config_reset_out_n)
    else $error("reset outputs not asserted while input low");
  cfg_after_cpu_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_processor_reset_out_n) |-> !o_config_reset_out_n ##2 o_config_reset_out_n)
    else $error("config reset not released two clocks after processor reset");
  cpu_hold_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_processor_reset_out_n) |-> cnt == HOLD_CNT)
    else $error("processor reset released at wrong count");
  init_width_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_init_start |-> s_init_hold)
    else $error("init pulse shorter than four clocks");
  shutdown_init_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_shutdown_cycle && state == CRG_ST_RUN |=> o_no_data_response ##[1:2] !o_init_n)
    else $error("shutdown did not produce response and init");
  strap_cap_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == CRG_ST_RESET && i_system_reset_in_n && !sys_d |=> o_straps == $past(i_straps))
    else $error("straps not captured at reset release");
  bist_ioq_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_in_order_queue_depth_one == o_cpu_reset_control[`CRG_BIT_BIST] && o_bist_req == o_in_order_queue_depth_one)
    else $error("self test without queue depth one");
  cnt_run_a : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == CRG_ST_HOLD && i_system_reset_in_n |=> cnt == $past(cnt) + 16'h0001)
    else $error("interval counter stalled");
endmodule : crg_reset_gen

// >>> dv/crg_bridge_model.sv
// bridge model that drives the system reset input
`timescale 1ns/1ps
module crg_bridge_model #(
  parameter int PWR_CYC = 50,
  parameter int LOW_CYC = 25000
) (
  input  wire logic i_clk,
  input  wire logic i_hard_req,
  output logic      o_system_reset_in_n = 1'b0
);
  int cnt = PWR_CYC;
  // power-up low time is short; each programmed request holds reset low a full millisecond
  always_ff @(posedge i_clk)
  begin
    if (i_hard_req)
      cnt <= LOW_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
    o_system_reset_in_n <= (cnt == 0) && !i_hard_req;
  end
endmodule : crg_bridge_model

// >>> dv/tb_top.sv
// self-checking bench for the cpu reset and init generator
`timescale 1ns/1ps
`include "crg_cfg.svh"
module tb_top;
  import crg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hard = 1'b0;
  logic        sd = 1'b0;
  logic        sys_n;
  crg_straps_t st = 3'b101;
  crg_cfg_wr_t cw = '0;
  logic        prst_n, crst_n, ndr, init_n, bist, qd1;
  crg_straps_t st_q;
  logic [7:0]  ctl;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  // free-running host clock
  always #20 clk = ~clk;
  crg_bridge_model #(.PWR_CYC(50)) BRG (
    .i_clk(clk), .i_hard_req(hard), .o_system_reset_in_n(sys_n));
  crg_reset_gen DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_system_reset_in_n(sys_n),
    .i_straps(st), .i_cfg_wr(cw), .i_shutdown_cycle(sd),
    .o_processor_reset_out_n(prst_n), .o_config_reset_out_n(crst_n),
    .o_no_data_response(ndr), .o_init_n(init_n), .o_bist_req(bist),
    .o_in_order_queue_depth_one(qd1), .o_straps(st_q),
    .o_cpu_reset_control(ctl));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cw = {1'b1, a, d};
    tick(1);
    cw = '0;
  endtask : wr
  task automatic t_init(input logic e);
    for (int i = 0; i < 5; i++)
    begin
      chk("init", {7'h00, !(e && i < 4)}, {7'h00, init_n});
      tick(1);
    end
  endtask : t_init
  task automatic t_refuse();
    wr(8'h93, 8'h06);
    t_init(1'b0);
    chk("ctl", 8'h00, ctl);
  endtask : t_refuse
  task automatic t_hold(input crg_straps_t s);
    st = s;
    chk("resets", 8'h00, {6'h00, prst_n, crst_n});
    while (sys_n !== 1'b1)
      tick(1);
    tick(1);
    st = ~s;
    tick(1);
    chk("strap", {5'h00, s}, {5'h00, st_q});
    tick(`CRG_HOLD_CYC - 2);
    chk("prst", 8'h00, {7'h00, prst_n});
    tick(1);
    chk("prst", 8'h01, {7'h00, prst_n});
    tick(1);
    chk("crst", 8'h00, {7'h00, crst_n});
    tick(1);
    chk("crst", 8'h01, {7'h00, crst_n});
  endtask : t_hold
  task automatic t_soft();
    wr(8'h93, 8'h02);
    t_init(1'b0);
    chk("ctl", 8'h02, ctl);
    wr(8'h93, 8'h06);
    t_init(1'b1);
    chk("ctl", 8'h06, ctl);
    wr(8'h92, 8'h00);
    chk("ctl", 8'h06, ctl);
  endtask : t_soft
  task automatic t_shutdown();
    sd = 1'b1;
    tick(1);
    sd = 1'b0;
    chk("ndr", 8'h01, {7'h00, ndr});
    tick(1);
    chk("ndr", 8'h00, {7'h00, ndr});
    t_init(1'b1);
  endtask : t_shutdown
  task automatic t_bist();
    wr(8'h93, 8'h02);
    tick(1);
    wr(8'h93, 8'h0e);
    t_init(1'b0);
    chk("bist", 8'h03, {6'h00, bist, qd1});
    hard = 1'b1;
    tick(1);
    hard = 1'b0;
    tick(3);
    chk("resets", 8'h00, {6'h00, prst_n, crst_n});
    chk("ctl", 8'h00, ctl);
    t_hold(3'b010);
  endtask : t_bist
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    tick(4);
    rst_n = 1'b1;
    t_refuse();
    t_hold(3'b101);
    t_soft();
    t_shutdown();
    t_bist();
    summarize();
  end
endmodule : tb_top
